/* hw/mim_pkg.sv */
package mim_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h28;
    localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR = 8'h2C;
    localparam logic [7:0] OFF_IRQ_MASK_STATE = 8'h30;
    localparam logic [7:0] OFF_PHY_MGMT_FRAME = 8'h34;
    localparam logic [7:0] OFF_PAUSE_COUNTER = 8'h38;
    localparam logic [7:0] OFF_HASH_FILTER_LOW = 8'h90;
    localparam logic [7:0] OFF_HASH_FILTER_HIGH = 8'h94;

    // Interrupt source bit positions
    localparam int IRQ_MGMT_DONE = 0;
    localparam int IRQ_RX_COMPLETE = 1;
    localparam int IRQ_RX_USED_BIT_SEEN = 2;
    localparam int IRQ_TX_USED_BIT_SEEN = 3;
    localparam int IRQ_TX_UNDERRUN = 4;
    localparam int IRQ_RETRY_LIMIT_HIT = 5;
    localparam int IRQ_TX_BUFFERS_EXHAUSTED = 6;
    localparam int IRQ_TX_COMPLETE = 7;
    localparam int IRQ_RX_OVERRUN = 10;
    localparam int IRQ_BUS_ERROR = 11;
    localparam int IRQ_PAUSE_FRAME_SEEN = 12;
    localparam int IRQ_PAUSE_TIME_ZERO = 13;
    localparam int IRQ_W = 14;

    // Defined interrupt bits, mask value after reset (all masked), status after reset
    localparam logic [31:0] IRQ_DEFINED = 32'h0000_3CFF;
    localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_3CFF;
    localparam logic [31:0] IRQ_STATUS_RESET = 32'h0000_0000;

    // Management frame fields
    localparam int MAN_OP_LSB = 28;
    localparam int MAN_DATA_W = 16;
    localparam logic [1:0] MAN_OP_READ = 2'h2;
    localparam logic [1:0] MAN_OP_WRITE = 2'h1;
    localparam logic [31:0] MAN_RESET = 32'h0000_0000;
    localparam logic [4:0] MAN_LAST_BIT = 5'h1F;
    localparam logic [4:0] MAN_TA_BIT = 5'h11;
    localparam logic [4:0] MAN_DATA_TOP = 5'h0F;

    // Management clock: half period in core cycles (2.5 MHz from 100 MHz)
    localparam int MDC_HALF_CYCLES = 20;

    // Pause quantum timing
    localparam int PAUSE_QUANTUM_BITS = 512;
    localparam int BIT_TIME_NS = 10;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PAUSE_TICK_CYCLES = PAUSE_QUANTUM_BITS * BIT_TIME_NS / CLK_PERIOD_NS;
    localparam logic [15:0] PAUSE_RESET = 16'h0000;
    localparam logic [31:0] HASH_RESET = 32'h0000_0000;

    // Management shifter states
    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_SHIFT = 2'b01,
        MS_DONE = 2'b10
    } mim_mdio_state_type;

    // Operation field of a frame asks the PHY for data
    function automatic logic mim_is_read(input logic [31:0] frame);
        return frame[MAN_OP_LSB +: 2] == MAN_OP_READ;
    endfunction

endpackage

/* hw/mim_core_if.sv */
`timescale 1ns/1ns
interface mim_core_if;
    logic mgmt_start;
    logic [31:0] mgmt_frame;
    logic mgmt_busy;
    logic mgmt_done;
    logic [15:0] mgmt_rdata;
    logic pause_load;
    logic [15:0] pause_wdata;
    logic [15:0] pause_count;
    logic pause_zero;

    modport ctl(output mgmt_start, mgmt_frame, pause_load, pause_wdata,
                input mgmt_busy, mgmt_done, mgmt_rdata, pause_count, pause_zero);
    modport mgmt(input mgmt_start, mgmt_frame, output mgmt_busy, mgmt_done, mgmt_rdata);
    modport pause(input pause_load, pause_wdata, output pause_count, pause_zero);
endinterface

/* hw/mim_mdio_shift.sv */
`timescale 1ns/1ns
module mim_mdio_shift import mim_pkg::*; #(
    parameter int MDC_HALF = MDC_HALF_CYCLES
) (
    input wire logic i_core_clk, // Core clock
    input wire logic i_reset, // Synchronous reset
    mim_core_if.mgmt bus, // Start and result
    input wire logic i_mdio_in, // Data line level
    output logic o_mdc, // Management clock
    output logic o_mdio_out, // Data line drive value
    output logic o_mdio_oe // Data line driven
);
    generate
        if (MDC_HALF < 1) begin : g_chk
            $error("MDC_HALF must be at least 1");
        end
    endgenerate

    mim_mdio_state_type state_q;
    logic [15:0] div_q;
    logic [31:0] frame_q;
    logic [4:0] bit_q;
    logic [4:0] bit_d;
    logic rd_q;
    logic done_q;
    logic [15:0] rdata_q;
    logic tick;

    assign tick = div_q == 16'(MDC_HALF - 1);
    assign bit_d = bit_q - 5'h01;
    assign bus.mgmt_busy = state_q != MS_IDLE;
    assign bus.mgmt_done = done_q;
    assign bus.mgmt_rdata = rdata_q;

    // Divider for the management clock half period
    always_ff @(posedge i_core_clk) begin
        if (i_reset || state_q == MS_IDLE || tick) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // Frame shifting, MSB first; line released from turnaround on reads
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_q <= MS_IDLE;
            frame_q <= 32'h0000_0000;
            bit_q <= 5'h00;
            rd_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
            o_mdc <= 1'b0;
            o_mdio_out <= 1'b0;
            o_mdio_oe <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                MS_IDLE: begin
                    if (bus.mgmt_start) begin
                        frame_q <= bus.mgmt_frame;
                        rd_q <= mim_is_read(bus.mgmt_frame);
                        bit_q <= MAN_LAST_BIT;
                        o_mdio_out <= bus.mgmt_frame[31];
                        o_mdio_oe <= 1'b1;
                        state_q <= MS_SHIFT;
                    end
                end
                MS_SHIFT: begin
                    if (tick) begin
                        o_mdc <= ~o_mdc;
                        if (!o_mdc) begin
                            if (rd_q && bit_q <= MAN_DATA_TOP) begin
                                rdata_q <= {rdata_q[14:0], i_mdio_in};
                            end
                            if (bit_q == 5'h00) begin
                                state_q <= MS_DONE;
                            end
                        end else begin
                            bit_q <= bit_d;
                            o_mdio_out <= frame_q[bit_d];
                            o_mdio_oe <= !(rd_q && bit_d <= MAN_TA_BIT);
                        end
                    end
                end
                MS_DONE: begin
                    if (tick) begin
                        o_mdc <= 1'b0;
                        o_mdio_oe <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= MS_IDLE;
                    end
                end
                default: begin
                    state_q <= MS_IDLE;
                end
            endcase
        end
    end

    AST_MDIO_START: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (state_q == MS_IDLE && bus.mgmt_start) |=> (bus.mgmt_busy && o_mdio_oe))
        else $error("frame did not start shifting");
endmodule

/* hw/mim_pause_ctr.sv */
`timescale 1ns/1ns
module mim_pause_ctr import mim_pkg::*; #(
    parameter int TICK_CYCLES = PAUSE_TICK_CYCLES
) (
    input wire logic i_core_clk, // Core clock
    input wire logic i_reset, // Synchronous reset
    mim_core_if.pause bus // Load and live count
);
    generate
        if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_chk
            $error("TICK_CYCLES out of range");
        end
    endgenerate

    logic [15:0] tick_q;
    logic [15:0] cnt_q;
    logic zero_q;
    logic tick;

    assign tick = tick_q == 16'(TICK_CYCLES - 1);
    assign bus.pause_count = cnt_q;
    assign bus.pause_zero = zero_q;

    // Quantum divider, restarted by a load
    always_ff @(posedge i_core_clk) begin
        if (i_reset || bus.pause_load || tick || cnt_q == 16'h0000) begin
            tick_q <= 16'h0000;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end

    // Live count and the event on reaching zero
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cnt_q <= PAUSE_RESET;
            zero_q <= 1'b0;
        end else begin
            zero_q <= 1'b0;
            if (bus.pause_load) begin
                cnt_q <= bus.pause_wdata;
            end else if (tick && cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
                zero_q <= cnt_q == 16'h0001;
            end
        end
    end

    AST_PAUSE_DEC: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (tick && cnt_q != 16'h0000 && !bus.pause_load) |=> cnt_q == $past(cnt_q) - 16'h0001)
        else $error("pause count did not step down");
endmodule

/* hw/mim_mac_regs.sv */
`timescale 1ns/1ns
// Contract
// - A write-only enable register unmasks the interrupt of each source whose bit is one.
// - A write-only disable register of the same layout masks each source whose bit is one.
// - A read-only mask register of the same layout shows which sources are masked.
// - Low byte: mgmt done 0, rx complete 1, rx used bit 2, tx used bit 3, underrun 4, retry 5, exhausted 6, tx complete 7.
// - Bits 10 to 13 are rx overrun, bus error, pause frame and pause zero; 8, 9, 14-31 unused.
// - The low 16 bits of the management register carry write data, and after a read frame the PHY's data.
// - Operation code 10 reads the PHY, 01 writes it, other codes make an invalid frame.
// - Completion of a management frame raises the done event, cleared by a status read.
// - The 16-bit pause count is live and steps down every 512 bit times while nonzero.
// - The pause count stepping down to zero raises the pause-zero event, cleared by a status read.
// - The low hash register stores hash filter bits 31 to 0 and reads them back.
// - The high hash register stores hash filter bits 63 to 32 and reads them back.
module mim_mac_regs import mim_pkg::*; #(
    parameter int MDC_HALF = MDC_HALF_CYCLES,
    parameter int PAUSE_TICKS = PAUSE_TICK_CYCLES
) (
    input wire logic i_core_clk, // Core clock, 100 MHz
    input wire logic i_reset, // Synchronous reset, active high
    input wire logic i_psel, // APB select
    input wire logic i_penable, // APB enable
    input wire logic i_pwrite, // APB direction
    input wire logic [ADDR_W-1:0] i_paddr, // APB byte address
    input wire logic [DATA_W-1:0] i_pwdata, // APB write data
    output logic [DATA_W-1:0] o_prdata, // APB read data
    output logic o_pready, // APB ready
    output logic o_pslverr, // APB error, unmapped address
    input wire logic [IRQ_W-1:0] i_evt, // Event pulses from the MAC
    output logic o_irq, // Interrupt, level
    output logic o_mdc, // Management clock
    output logic o_mdio_out, // Management data drive value
    output logic o_mdio_oe, // Management data driven
    input wire logic i_mdio_in, // Management data level
    output logic o_mgmt_busy, // Frame in progress
    output logic o_pause_active, // Pause count nonzero
    output logic [63:0] o_hash_filter // Hash filter bits
);
    mim_core_if core();

    logic pready_q;
    logic slverr_q;
    logic [31:0] prdata_q;
    logic [31:0] status_q;
    logic [31:0] mask_q;
    logic [31:0] man_q;
    logic [31:0] hash_lo_q;
    logic [31:0] hash_hi_q;
    logic start_q;
    logic load_q;
    logic [15:0] load_val_q;
    logic irq_q;
    logic busy_q;
    logic active_q;
    logic acc;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] wdata_def;
    logic [31:0] evt_vec;
    logic [31:0] rd_mux;
    logic irq_d;

    // Register offset is one this block answers
    function automatic logic reg_mapped(input logic [7:0] a);
        return a == OFF_IRQ_STATUS || a == OFF_IRQ_ENABLE_SET ||
               a == OFF_IRQ_ENABLE_CLEAR || a == OFF_IRQ_MASK_STATE ||
               a == OFF_PHY_MGMT_FRAME || a == OFF_PAUSE_COUNTER ||
               a == OFF_HASH_FILTER_LOW || a == OFF_HASH_FILTER_HIGH;
    endfunction

    // Bus phase decode
    assign acc = i_psel && i_penable;
    assign wr_fire = acc && pready_q && i_pwrite;
    assign rd_fire = acc && pready_q && !i_pwrite;
    assign wdata_def = i_pwdata & IRQ_DEFINED;

    // Event vector in register layout; done and pause zero come from inside
    always_comb begin
        evt_vec = 32'h0000_0000;
        evt_vec[IRQ_W-1:0] = i_evt;
        evt_vec[IRQ_MGMT_DONE] = core.mgmt_done;
        evt_vec[IRQ_PAUSE_TIME_ZERO] = core.pause_zero;
        evt_vec = evt_vec & IRQ_DEFINED;
    end

    // Read data selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (i_paddr)
            OFF_IRQ_STATUS: rd_mux = status_q;
            OFF_IRQ_MASK_STATE: rd_mux = mask_q;
            OFF_PHY_MGMT_FRAME: rd_mux = man_q;
            OFF_PAUSE_COUNTER: rd_mux = {16'h0000, core.pause_count};
            OFF_HASH_FILTER_LOW: rd_mux = hash_lo_q;
            OFF_HASH_FILTER_HIGH: rd_mux = hash_hi_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // APB answer: ready in the second access cycle, data and error with it
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pready_q <= 1'b0;
            slverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc && !pready_q;
            if (acc && !pready_q) begin
                slverr_q <= !reg_mapped(i_paddr);
                prdata_q <= i_pwrite ? 32'h0000_0000 : rd_mux;
            end else begin
                slverr_q <= 1'b0;
            end
        end
    end

    // Sticky status; a read clears only the bits it reported, new events win
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            status_q <= IRQ_STATUS_RESET;
        end else if (rd_fire && i_paddr == OFF_IRQ_STATUS) begin
            status_q <= (status_q & ~prdata_q) | evt_vec;
        end else begin
            status_q <= status_q | evt_vec;
        end
    end

    // Mask: enable clears, disable sets, zeros leave bits alone
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            mask_q <= IRQ_MASK_RESET;
        end else if (wr_fire && i_paddr == OFF_IRQ_ENABLE_SET) begin
            mask_q <= mask_q & ~wdata_def;
        end else if (wr_fire && i_paddr == OFF_IRQ_ENABLE_CLEAR) begin
            mask_q <= mask_q | wdata_def;
        end
    end

    // Interrupt level from unmasked status
    assign irq_d = |(status_q & ~mask_q);
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Management register; writes while busy are ignored
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            man_q <= MAN_RESET;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_fire && i_paddr == OFF_PHY_MGMT_FRAME && !core.mgmt_busy && !start_q) begin
                man_q <= i_pwdata;
                start_q <= 1'b1;
            end else if (core.mgmt_done && mim_is_read(man_q)) begin
                man_q[MAN_DATA_W-1:0] <= core.mgmt_rdata;
            end
        end
    end

    // Pause counter load
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            load_q <= 1'b0;
            load_val_q <= PAUSE_RESET;
        end else begin
            load_q <= wr_fire && i_paddr == OFF_PAUSE_COUNTER;
            if (wr_fire && i_paddr == OFF_PAUSE_COUNTER) begin
                load_val_q <= i_pwdata[15:0];
            end
        end
    end

    // Hash filter words
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            hash_lo_q <= HASH_RESET;
            hash_hi_q <= HASH_RESET;
        end else begin
            if (wr_fire && i_paddr == OFF_HASH_FILTER_LOW) begin
                hash_lo_q <= i_pwdata;
            end
            if (wr_fire && i_paddr == OFF_HASH_FILTER_HIGH) begin
                hash_hi_q <= i_pwdata;
            end
        end
    end

    // Status outputs
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            busy_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            busy_q <= core.mgmt_busy || start_q;
            active_q <= core.pause_count != 16'h0000;
        end
    end

    assign core.mgmt_start = start_q;
    assign core.mgmt_frame = man_q;
    assign core.pause_load = load_q;
    assign core.pause_wdata = load_val_q;

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = slverr_q;
    assign o_irq = irq_q;
    assign o_mgmt_busy = busy_q;
    assign o_pause_active = active_q;
    assign o_hash_filter = {hash_hi_q, hash_lo_q};

    // Serial management shifter
    mim_mdio_shift #(.MDC_HALF(MDC_HALF)) u_mdio (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .bus(core.mgmt),
        .i_mdio_in(i_mdio_in),
        .o_mdc(o_mdc),
        .o_mdio_out(o_mdio_out),
        .o_mdio_oe(o_mdio_oe)
    );

    // Pause quantum counter
    mim_pause_ctr #(.TICK_CYCLES(PAUSE_TICKS)) u_pause (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .bus(core.pause)
    );

    // Checks on the register logic
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    AST_ENABLE_UNMASKS: assert property (
        (wr_fire && i_paddr == OFF_IRQ_ENABLE_SET) |=> (mask_q & $past(wdata_def)) == 32'h0)
        else $error("enable write left a source masked");

    AST_DISABLE_MASKS: assert property (
        (wr_fire && i_paddr == OFF_IRQ_ENABLE_CLEAR)
        |=> (mask_q & $past(wdata_def)) == $past(wdata_def))
        else $error("disable write left a source unmasked");

    AST_MASK_READBACK: assert property (
        (acc && !pready_q && !i_pwrite && i_paddr == OFF_IRQ_MASK_STATE)
        |=> o_pready && o_prdata == $past(mask_q))
        else $error("mask read returned wrong value");

    AST_UNUSED_ZERO: assert property (
        ((status_q | mask_q) & ~IRQ_DEFINED) == 32'h0)
        else $error("unused interrupt bit set");

    AST_IRQ_LEVEL: assert property (
        ##1 (o_irq == $past(irq_d)))
        else $error("irq does not follow unmasked status");

    AST_TX_DONE_MAP: assert property (
        i_evt[IRQ_TX_COMPLETE] |=> status_q[IRQ_TX_COMPLETE])
        else $error("tx complete not latched at bit 7");

    AST_MGMT_DONE_EVT: assert property (
        core.mgmt_done |=> status_q[IRQ_MGMT_DONE])
        else $error("management done not latched");

    AST_PAUSE_ZERO_EVT: assert property (
        core.pause_zero |-> core.pause_count == 16'h0000 ##1 status_q[IRQ_PAUSE_TIME_ZERO])
        else $error("pause zero not latched");

    AST_READ_DATA_KEPT: assert property (
        (core.mgmt_done && mim_is_read(man_q)
        && !(wr_fire && i_paddr == OFF_PHY_MGMT_FRAME))
        |=> man_q[MAN_DATA_W-1:0] == $past(core.mgmt_rdata))
        else $error("PHY read data not stored");

    AST_HASH_LOW: assert property (
        (wr_fire && i_paddr == OFF_HASH_FILTER_LOW) |=> hash_lo_q == $past(i_pwdata))
        else $error("low hash word not stored");

    AST_HASH_HIGH: assert property (
        (wr_fire && i_paddr == OFF_HASH_FILTER_HIGH)
        |=> o_hash_filter[63:32] == $past(i_pwdata))
        else $error("high hash word not stored");

    // Ones act on their own bits only, zeros leave the mask alone
    AST_ZERO_NO_EFFECT: assert property (
        (wr_fire && (i_paddr == OFF_IRQ_ENABLE_SET || i_paddr == OFF_IRQ_ENABLE_CLEAR))
        |=> (mask_q & ~$past(wdata_def)) == ($past(mask_q) & ~$past(wdata_def)))
        else $error("mask bit changed without a one written");

    // Status bits stay set until a status read
    AST_STATUS_STICKY: assert property (
        !(rd_fire && i_paddr == OFF_IRQ_STATUS)
        |=> (status_q & $past(status_q)) == $past(status_q))
        else $error("status bit dropped without a read");

    // A status read with no new event clears what it returned
    AST_STATUS_READ_CLEARS: assert property (
        (rd_fire && i_paddr == OFF_IRQ_STATUS && evt_vec == 32'h0)
        |=> (status_q & $past(prdata_q)) == 32'h0)
        else $error("status read did not clear");

    // Write-only registers read as zero
    AST_WRITE_ONLY_READ: assert property (
        (acc && !pready_q && !i_pwrite
        && (i_paddr == OFF_IRQ_ENABLE_SET || i_paddr == OFF_IRQ_ENABLE_CLEAR))
        |=> o_prdata == 32'h0)
        else $error("write-only register read nonzero");

    // Management register reads back its current contents
    AST_MGMT_READBACK: assert property (
        (acc && !pready_q && !i_pwrite && i_paddr == OFF_PHY_MGMT_FRAME)
        |=> o_prdata == $past(man_q))
        else $error("management register read wrong");

    // A write during a frame leaves the register alone
    AST_MGMT_BUSY_HOLD: assert property (
        (wr_fire && i_paddr == OFF_PHY_MGMT_FRAME && (core.mgmt_busy || start_q))
        |=> $stable(man_q))
        else $error("management register changed while busy");

    AST_MGMT_BUSY_OUT: assert property (
        start_q |=> o_mgmt_busy)
        else $error("busy not shown after start");

    // Pause count loads and reads back live
    AST_PAUSE_LOAD: assert property (
        load_q |=> core.pause_count == $past(load_val_q))
        else $error("pause count not loaded");

    AST_PAUSE_READ: assert property (
        (acc && !pready_q && !i_pwrite && i_paddr == OFF_PAUSE_COUNTER)
        |=> o_prdata == {16'h0000, $past(core.pause_count)})
        else $error("pause count read wrong");

    AST_HASH_HIGH_READ: assert property (
        (acc && !pready_q && !i_pwrite && i_paddr == OFF_HASH_FILTER_HIGH)
        |=> o_prdata == $past(hash_hi_q))
        else $error("high hash word read wrong");
endmodule

/* verif/mim_phy_model.sv */
`timescale 1ns/1ns
module mim_phy_model (
    input wire logic i_mdc, // Management clock
    input wire logic i_mdio_oe, // Host drives the line
    input wire logic i_mdio_out, // Host drive value
    input wire logic [15:0] i_rd_data, // Data returned on reads
    output logic o_mdio, // Line level, pulled up when free
    output logic [31:0] o_frame // Bits seen on the line
);
    int cnt = 0;
    logic rdop = 1'b0;
    logic drv = 1'b0;
    logic bitv = 1'b1;
    // Resolve the line; a free line floats high
    assign o_mdio = i_mdio_oe ? i_mdio_out : (drv ? bitv : 1'b1);
    // Capture each bit on the rising clock and decode the operation
    always @(posedge i_mdc) begin
        o_frame <= {o_frame[30:0], o_mdio};
        cnt <= (cnt == 31) ? 0 : cnt + 1;
        if (cnt == 4) begin
            rdop <= (o_frame[1:0] == 2'b10);
        end
    end
    // Present read data MSB first on the falling clock
    always @(negedge i_mdc) begin
        drv <= rdop && cnt >= 16;
        bitv <= i_rd_data[(31 - cnt) % 16];
    end
endmodule

/* verif/mac_irq_mgmt_pause_hash_regs_bench.sv */
`timescale 1ns/1ns
module mac_irq_mgmt_pause_hash_regs_bench import mim_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [13:0] evt = 14'h0000;
    logic [15:0] phy_data = 16'h0000;
    logic [31:0] prdata, phy_frame, rd, cmd, v, mask_m;
    logic pready, pslverr, irq, mdc, mdo, moe, mdi, busy, pact, err;
    logic [63:0] hash;
    int num_errors = 0;
    int checks = 0;
    int seed = 32'h49ad;
    int n;
    localparam int PT = 4;
    mim_mac_regs #(.MDC_HALF(2), .PAUSE_TICKS(PT)) u_dut (.i_core_clk(clk), .i_reset(rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_evt(evt), .o_irq(irq),
        .o_mdc(mdc), .o_mdio_out(mdo), .o_mdio_oe(moe), .i_mdio_in(mdi), .o_mgmt_busy(busy),
        .o_pause_active(pact), .o_hash_filter(hash));
    mim_phy_model u_phy (.i_mdc(mdc), .i_mdio_oe(moe), .i_mdio_out(mdo), .i_rd_data(phy_data),
        .o_mdio(mdi), .o_frame(phy_frame));
    // Core clock, 100 MHz
    initial begin
        forever #5 clk = ~clk;
    end
    // Compare and count
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("Checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Cut a hang short
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        mask_m = IRQ_MASK_RESET;
        apb(0, OFF_IRQ_MASK_STATE, 0);
        check("mask reset", rd, mask_m);
        apb(0, OFF_IRQ_ENABLE_SET, 0);
        check("enable read", rd, 0);
        apb(0, 8'h00, 0);
        check("unmapped", {err, rd}, {1'b1, 32'h0});
        for (int i = 0; i < 16; i++) begin
            v = 32'h1 << i;
            apb(1, OFF_IRQ_ENABLE_SET, v);
            mask_m &= ~(v & IRQ_DEFINED);
            apb(0, OFF_IRQ_MASK_STATE, 0);
            check("mask after enable", rd, mask_m);
            if ((v & IRQ_DEFINED & ~32'h2001) != 0) begin
                evt <= v[13:0];
                @(posedge clk);
                evt <= 14'h0000;
                repeat (2) @(posedge clk);
                check("irq unmasked", irq, 1);
                apb(1, OFF_IRQ_ENABLE_CLEAR, v);
                mask_m |= v;
                repeat (2) @(posedge clk);
                check("irq masked", irq, 0);
                apb(0, OFF_IRQ_STATUS, 0);
                check("status bit", rd, v);
            end
        end
        repeat (6) begin
            v = $random(seed);
            n = $random(seed) & 1;
            apb(1, n ? OFF_IRQ_ENABLE_SET : OFF_IRQ_ENABLE_CLEAR, v);
            mask_m = n ? mask_m & ~(v & IRQ_DEFINED) : mask_m | (v & IRQ_DEFINED);
            apb(0, OFF_IRQ_MASK_STATE, 0);
            check("mask random", rd, mask_m);
        end
        cmd = $random(seed);
        v = $random(seed);
        apb(1, OFF_HASH_FILTER_LOW, cmd);
        apb(1, OFF_HASH_FILTER_HIGH, v);
        apb(0, OFF_HASH_FILTER_LOW, 0);
        check("hash low", rd, cmd);
        apb(0, OFF_HASH_FILTER_HIGH, 0);
        check("hash high", rd, v);
        check("hash out", hash, {v, cmd});
        apb(1, OFF_IRQ_ENABLE_SET, 32'h1);
        // Write frame then read frame; addresses random, fixed fields per protocol
        for (int op = 1; op < 3; op++) begin
            phy_data = $random(seed);
            cmd = $random(seed);
            cmd[31:28] = {2'b01, op[1:0]};
            cmd[17:16] = 2'b10;
            apb(1, OFF_PHY_MGMT_FRAME, cmd);
            @(posedge clk);
            check("busy set", busy, 1);
            while (irq !== 1'b1) begin
                @(posedge clk);
            end
            repeat (4) @(posedge clk);
            v = (op == 2) ? {cmd[31:18], 2'b11, phy_data} : cmd;
            check("phy frame", phy_frame, v);
            check("busy", busy, 0);
            apb(0, OFF_PHY_MGMT_FRAME, 0);
            check("mgmt reg", rd, (op == 2) ? {cmd[31:16], phy_data} : cmd);
            apb(0, OFF_IRQ_STATUS, 0);
            check("done status", rd, 32'h1);
            repeat (2) @(posedge clk);
            check("irq cleared", irq, 0);
        end
        apb(1, OFF_IRQ_ENABLE_SET, 32'h2000);
        apb(1, OFF_PAUSE_COUNTER, 32'h3);
        repeat (2) @(posedge clk);
        n = 0;
        while (pact === 1'b1) begin
            @(posedge clk);
            n++;
        end
        check("pause span", n, 3 * PT);
        repeat (2) @(posedge clk);
        check("pause irq", irq, 1);
        apb(0, OFF_PAUSE_COUNTER, 0);
        check("pause count", rd, 0);
        apb(0, OFF_IRQ_STATUS, 0);
        check("pause zero", rd, 32'h2000);
        print_verdict();
    end
endmodule
